// ---- hdl/pad_function_mux.sv ----
/*
  Pad function multiplexer: one select register decides for each group
  of shared pads whether the main or the alternate peripheral owns it.
  Assumes a single-cycle register port with read data one cycle later,
  and peripherals that drive and sample plain per-pad vectors.
  // How it works
  // - Bit 28 moves stream clock to satnav clock
  // - Bit 27 gives RTS pad to satnav mode2
  // - Bit 26 gives stream sync to mode1
  // - Bit 25 gives stream valid to mode0
  // - Bit 24 gives stream data to sample
  // - Bit 23 puts second UART on display pads
  // - Bit 22 turns second SPI into stream
  // - Bit 21 swaps baseband audio for power interface
  // - Bit 20 makes third serial device pads
  // - Bit 19 makes second serial device pads
  // - Bit 18 makes first serial device pads
  // - Bit 17 puts MMC-plus on flash pads
  // - Bit 16 puts reference clock on TXD
  // - Bit 15 puts codec clock on data3
  // - Bit 14 puts system clock on data2
  // - Bit 13 puts memory clock on data1
  // - Bit 12 puts interface clock on data0
  // - Bits 11,10 give keypad scan outputs three, two
  // - Bits 9..4 give remaining keypad scan lines
  // - Bits 3,2 give secondary I2C pads
  // - Bits 1,0 give PWM outputs
*/
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module pad_function_mux
  import pad_function_mux_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [31:0]         rdata,
  // Pads
  input  wire logic [NUM_PADS-1:0] pad_in,
  output logic      [NUM_PADS-1:0] pad_out,
  output logic      [NUM_PADS-1:0] pad_oe,
  // Main functions
  input  wire logic [NUM_PADS-1:0] main_out,
  input  wire logic [NUM_PADS-1:0] main_oe,
  output logic      [NUM_PADS-1:0] main_in,
  // Alternate functions
  input  wire logic [NUM_PADS-1:0] alt_out,
  input  wire logic [NUM_PADS-1:0] alt_oe,
  output logic      [NUM_PADS-1:0] alt_in,
  // Second serial device select, shares the RTS pad
  input  wire logic                dev2_sel_out,
  input  wire logic                dev2_sel_oe,
  output logic                     dev2_sel_in,
  // Current selection, for peripherals that care
  output logic      [SEL_W-1:0]    pad_select
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W != 32) begin : g_bad_addr
    $error("pad_function_mux: ADDR_W must be 32");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [31:0]      rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic                hit;
  logic [NUM_PADS-1:0] pad_sel;
  logic [NUM_PADS-1:0] eff_alt_out;
  logic [NUM_PADS-1:0] eff_alt_oe;
  logic [NUM_PADS-1:0] cell_alt_in;
  logic                rts_sat;
  logic                rts_dev2;

  assign hit = (addr == SEL_ADDR);

  // ------------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------------
  // Read data live only in the cycle after the strobe
  always_comb begin
    next_cur       = cur;
    next_cur.rdata = '0;
    if (wr && hit) begin
      next_cur.sel = wdata[SEL_W-1:0];
    end
    if (rd && hit) begin
      next_cur.rdata = {{(32-SEL_W){1'b0}}, cur.sel};
    end
  end

  // Whole state cleared by reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '{sel: SEL_RESET[SEL_W-1:0], rdata: 32'h0000_0000};
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata      = cur.rdata;
  assign pad_select = cur.sel;

  // ------------------------------------------------------------------
  // Pad to select bit map
  // ------------------------------------------------------------------
  function automatic logic [4:0] pad_bit(input int p);
    logic [4:0] b;
    b = BIT_PWM1;
    case (p)
      PAD_TS_CLK:    b = BIT_SATNAV_CLOCK;
      PAD_UART_RTS:  b = BIT_SATNAV_MODE2;
      PAD_TS_SYNC:   b = BIT_SATNAV_MODE1;
      PAD_TS_VALID:  b = BIT_SATNAV_MODE0;
      PAD_TS_DATA:   b = BIT_SATNAV_SAMPLE;
      PAD_DISP_D22:  b = BIT_SECOND_SERIAL;
      PAD_DISP_D23:  b = BIT_SECOND_SERIAL;
      PAD_SPI2_BASE,
      PAD_SPI2_BASE + 1,
      PAD_SPI2_BASE + 2,
      PAD_SPI2_BASE + 3: b = BIT_SERIAL_STREAM;
      PAD_RSVD3:     b = BIT_POWER_IF;
      PAD_RSVD4:     b = BIT_POWER_IF;
      PAD_RSVD15:    b = BIT_SERIAL_DEV3;
      PAD_SC_VOLT:   b = BIT_SERIAL_DEV3;
      PAD_CE_FOURTH: b = BIT_SERIAL_DEV2;
      PAD_UART_CTS:  b = BIT_SERIAL_DEV1;
      PAD_CE_THIRD:  b = BIT_SERIAL_DEV1;
      PAD_CE_FIRST:  b = BIT_MMC_PLUS;
      PAD_CE_SECOND: b = BIT_MMC_PLUS;
      PAD_UART_TXD:  b = BIT_TX_REF_CLOCK;
      PAD_CARD_D3:   b = BIT_CODEC_CLOCK;
      PAD_CARD_D3+1: b = BIT_SYS_CLOCK;
      PAD_CARD_D3+2: b = BIT_MEM_CLOCK;
      PAD_CARD_D0:   b = BIT_IF_CLOCK;
      PAD_RSVD14:    b = BIT_KEY_OUT3;
      PAD_RSVD14+1:  b = BIT_KEY_OUT2;
      PAD_DISP_D17:  b = BIT_I2C2_CLOCK;
      PAD_DISP_D16:  b = BIT_I2C2_DATA;
      PAD_AUDIO_FSR: b = BIT_PWM2;
      PAD_SC_FCB:    b = BIT_PWM1;
      default: begin
        if (p >= PAD_NAND_D0 && p <= PAD_NAND_D7) begin
          b = BIT_MMC_PLUS;
        end else if (p > PAD_RSVD14 + 1 && p <= PAD_RSVD7) begin
          // Keypad lines run down from bit 9 as the pad index rises
          b = 5'(int'(BIT_KEY_OUT1) - (p - (PAD_RSVD14 + 2)));
        end
      end
    endcase
    return b;
  endfunction : pad_bit

  // ------------------------------------------------------------------
  // The RTS pad has two alternates
  // ------------------------------------------------------------------
  // Satnav mode line wins if software sets both bits
  assign rts_sat  = cur.sel[BIT_SATNAV_MODE2];
  assign rts_dev2 = !rts_sat && cur.sel[BIT_SERIAL_DEV2];

  // ------------------------------------------------------------------
  // Per-pad routing
  // ------------------------------------------------------------------
  for (genvar g = 0; g < NUM_PADS; g++) begin : g_pad
    if (g == PAD_UART_RTS) begin : g_rts
      assign pad_sel[g]     = rts_sat || rts_dev2;
      assign eff_alt_out[g] = rts_sat ? alt_out[g] : dev2_sel_out;
      assign eff_alt_oe[g]  = rts_sat ? alt_oe[g] : dev2_sel_oe;
      assign alt_in[g]      = rts_sat ? cell_alt_in[g] : ALT_IDLE[g];
    end else begin : g_plain
      assign pad_sel[g]     = cur.sel[pad_bit(g)];
      assign eff_alt_out[g] = alt_out[g];
      assign eff_alt_oe[g]  = alt_oe[g];
      assign alt_in[g]      = cell_alt_in[g];
    end

    pad_route_cell #(
      .MAIN_IDLE_LVL (MAIN_IDLE[g]),
      .ALT_IDLE_LVL  (ALT_IDLE[g])
    ) u_cell (
      .sel      (pad_sel[g]),
      .pad_in   (pad_in[g]),
      .pad_out  (pad_out[g]),
      .pad_oe   (pad_oe[g]),
      .main_out (main_out[g]),
      .main_oe  (main_oe[g]),
      .main_in  (main_in[g]),
      .alt_out  (eff_alt_out[g]),
      .alt_oe   (eff_alt_oe[g]),
      .alt_in   (cell_alt_in[g])
    );
  end

  // Second device select sees the pad only while it owns it
  assign dev2_sel_in = rts_dev2 ? pad_in[PAD_UART_RTS] : ALT_IDLE[PAD_UART_RTS];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_SAT_CLOCK: assert property (
    @(posedge clk) disable iff (!resetn)
    cur.sel[28] |-> alt_in[PAD_TS_CLK] == pad_in[PAD_TS_CLK]
                    && main_in[PAD_TS_CLK] == MAIN_IDLE[PAD_TS_CLK])
    else $error("stream clock pad not given to satnav");

  AST_RTS_MODE2: assert property (
    @(posedge clk) disable iff (!resetn)
    cur.sel[27] |-> pad_out[PAD_UART_RTS] == alt_out[PAD_UART_RTS]
                    && dev2_sel_in == ALT_IDLE[PAD_UART_RTS])
    else $error("RTS pad not owned by satnav mode2");

  AST_RTS_DEV2: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cur.sel[27] && cur.sel[19]) |-> pad_oe[PAD_UART_RTS] == dev2_sel_oe
                    && pad_out[PAD_CE_FOURTH] == alt_out[PAD_CE_FOURTH])
    else $error("RTS pad not owned by second serial device");

  AST_SECOND_UART: assert property (
    @(posedge clk) disable iff (!resetn)
    cur.sel[23] |-> alt_in[PAD_DISP_D22] == pad_in[PAD_DISP_D22]
                    && pad_out[PAD_DISP_D23] == alt_out[PAD_DISP_D23])
    else $error("second UART not on display pads");

  AST_MMC_PLUS: assert property (
    @(posedge clk) disable iff (!resetn)
    cur.sel[17] |-> pad_oe[PAD_NAND_D7:PAD_NAND_D0] == alt_oe[PAD_NAND_D7:PAD_NAND_D0]
                    && pad_out[PAD_CE_FIRST] == alt_out[PAD_CE_FIRST])
    else $error("MMC-plus not on flash pads");

  AST_TXD_MAIN: assert property (
    @(posedge clk) disable iff (!resetn)
    !cur.sel[16] |-> pad_out[PAD_UART_TXD] == main_out[PAD_UART_TXD])
    else $error("TXD pad lost its UART while bit clear");

  AST_WRITE_TAKES: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr && hit) |=> pad_select == $past(wdata[SEL_W-1:0]))
    else $error("select write not applied next cycle");

  AST_READ_BACK: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && hit) |=> rdata == {3'h0, $past(cur.sel)} ##1 rdata == 32'h0000_0000
                    || $past(rd, 1) && rdata[31:29] == 3'h0)
    else $error("read data wrong or not one cycle");

  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && !hit) |=> rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  AST_IDLE_INPUTS: assert property (
    @(posedge clk) disable iff (!resetn)
    ((main_in ^ MAIN_IDLE) & pad_sel) == '0
    && ((alt_in ^ ALT_IDLE) & ~pad_sel) == '0)
    else $error("unselected function sees pad activity");

  AST_KEYPAD: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_sel[PAD_RSVD7:PAD_RSVD14+2] ==
      {cur.sel[4], cur.sel[5], cur.sel[6], cur.sel[7], cur.sel[8], cur.sel[9]})
    else $error("keypad pads follow the wrong bits");

  // Rules for bits 26, 24, 22 to 20, 18, 15 to 11, 3 and 1 checked from the outputs, with the bit clear and with it set
  AST_STREAM_SYNC: assert property (
    @(posedge clk) disable iff (!resetn)
    main_in[PAD_TS_SYNC] == (cur.sel[BIT_SATNAV_MODE1]
      ? MAIN_IDLE[PAD_TS_SYNC] : pad_in[PAD_TS_SYNC]))
    else $error("sync pad input not steered by its bit");

  AST_STREAM_DATA: assert property (
    @(posedge clk) disable iff (!resetn)
    alt_in[PAD_TS_DATA] == (cur.sel[BIT_SATNAV_SAMPLE]
      ? pad_in[PAD_TS_DATA] : ALT_IDLE[PAD_TS_DATA]))
    else $error("data pad not given to satnav sample");

  AST_SPI_STREAM: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_oe[PAD_SPI2_BASE+3:PAD_SPI2_BASE] == (cur.sel[BIT_SERIAL_STREAM]
      ? alt_oe[PAD_SPI2_BASE+3:PAD_SPI2_BASE] : main_oe[PAD_SPI2_BASE+3:PAD_SPI2_BASE]))
    else $error("second serial pads not steered by their bit");

  AST_POWER_IF: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_out[PAD_RSVD4:PAD_RSVD3] == (cur.sel[BIT_POWER_IF]
      ? alt_out[PAD_RSVD4:PAD_RSVD3] : main_out[PAD_RSVD4:PAD_RSVD3]))
    else $error("power interface pads not steered by their bit");

  AST_SERIAL_DEV3: assert property (
    @(posedge clk) disable iff (!resetn)
    alt_in[PAD_SC_VOLT] == (cur.sel[BIT_SERIAL_DEV3]
      ? pad_in[PAD_SC_VOLT] : ALT_IDLE[PAD_SC_VOLT]))
    else $error("third serial device receive not steered");

  AST_SERIAL_DEV1: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_oe[PAD_CE_THIRD:PAD_UART_CTS] == (cur.sel[BIT_SERIAL_DEV1]
      ? alt_oe[PAD_CE_THIRD:PAD_UART_CTS] : main_oe[PAD_CE_THIRD:PAD_UART_CTS]))
    else $error("first serial device pads not steered");

  AST_CODEC_CLOCK: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_out[PAD_CARD_D3] == (cur.sel[BIT_CODEC_CLOCK]
      ? alt_out[PAD_CARD_D3] : main_out[PAD_CARD_D3]))
    else $error("card data3 pad not steered by its bit");

  AST_SYS_CLOCK: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_out[PAD_CARD_D3+1] == (cur.sel[BIT_SYS_CLOCK]
      ? alt_out[PAD_CARD_D3+1] : main_out[PAD_CARD_D3+1]))
    else $error("card data2 pad not steered by its bit");

  AST_MEM_CLOCK: assert property (
    @(posedge clk) disable iff (!resetn)
    main_in[PAD_CARD_D3+2] == (cur.sel[BIT_MEM_CLOCK]
      ? MAIN_IDLE[PAD_CARD_D3+2] : pad_in[PAD_CARD_D3+2]))
    else $error("card data1 input not steered by its bit");

  AST_IF_CLOCK: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_out[PAD_CARD_D0] == (cur.sel[BIT_IF_CLOCK]
      ? alt_out[PAD_CARD_D0] : main_out[PAD_CARD_D0]))
    else $error("card data0 pad not steered by its bit");

  AST_KEY_OUT3: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_out[PAD_RSVD14] == (cur.sel[BIT_KEY_OUT3]
      ? alt_out[PAD_RSVD14] : main_out[PAD_RSVD14]))
    else $error("keypad out three pad not steered");

  AST_I2C2_CLOCK: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_oe[PAD_DISP_D17] == (cur.sel[BIT_I2C2_CLOCK]
      ? alt_oe[PAD_DISP_D17] : main_oe[PAD_DISP_D17]))
    else $error("display pad 17 not steered by its bit");

  AST_PWM2: assert property (
    @(posedge clk) disable iff (!resetn)
    pad_out[PAD_AUDIO_FSR] == (cur.sel[BIT_PWM2]
      ? alt_out[PAD_AUDIO_FSR] : main_out[PAD_AUDIO_FSR]))
    else $error("audio frame pad not steered by its bit");

endmodule : pad_function_mux

// ---- hdl/pad_function_mux_pkg.sv ----
/*
  Constants for the pad function multiplexer: register address, select
  field positions, pad index map and idle levels of unselected inputs.
  Assumes a 32-bit byte-addressed register port.
*/
package pad_function_mux_pkg;

  // ------------------------------------------------------------------
  // Register
  // ------------------------------------------------------------------
  localparam logic [31:0] SEL_ADDR  = 32'hD003_0030;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam int          SEL_W     = 29;

  // ------------------------------------------------------------------
  // Select field positions
  // ------------------------------------------------------------------
  localparam logic [4:0] BIT_SATNAV_CLOCK   = 5'h1C;
  localparam logic [4:0] BIT_SATNAV_MODE2   = 5'h1B;
  localparam logic [4:0] BIT_SATNAV_MODE1   = 5'h1A;
  localparam logic [4:0] BIT_SATNAV_MODE0   = 5'h19;
  localparam logic [4:0] BIT_SATNAV_SAMPLE  = 5'h18;
  localparam logic [4:0] BIT_SECOND_SERIAL  = 5'h17;
  localparam logic [4:0] BIT_SERIAL_STREAM  = 5'h16;
  localparam logic [4:0] BIT_POWER_IF       = 5'h15;
  localparam logic [4:0] BIT_SERIAL_DEV3    = 5'h14;
  localparam logic [4:0] BIT_SERIAL_DEV2    = 5'h13;
  localparam logic [4:0] BIT_SERIAL_DEV1    = 5'h12;
  localparam logic [4:0] BIT_MMC_PLUS       = 5'h11;
  localparam logic [4:0] BIT_TX_REF_CLOCK   = 5'h10;
  localparam logic [4:0] BIT_CODEC_CLOCK    = 5'h0F;
  localparam logic [4:0] BIT_SYS_CLOCK      = 5'h0E;
  localparam logic [4:0] BIT_MEM_CLOCK      = 5'h0D;
  localparam logic [4:0] BIT_IF_CLOCK       = 5'h0C;
  localparam logic [4:0] BIT_KEY_OUT3       = 5'h0B;
  localparam logic [4:0] BIT_KEY_OUT2       = 5'h0A;
  localparam logic [4:0] BIT_KEY_OUT1       = 5'h09;
  localparam logic [4:0] BIT_KEY_OUT0       = 5'h08;
  localparam logic [4:0] BIT_KEY_IN3        = 5'h07;
  localparam logic [4:0] BIT_KEY_IN2        = 5'h06;
  localparam logic [4:0] BIT_KEY_IN1        = 5'h05;
  localparam logic [4:0] BIT_KEY_IN0        = 5'h04;
  localparam logic [4:0] BIT_I2C2_CLOCK     = 5'h03;
  localparam logic [4:0] BIT_I2C2_DATA      = 5'h02;
  localparam logic [4:0] BIT_PWM2           = 5'h01;
  localparam logic [4:0] BIT_PWM1           = 5'h00;

  // ------------------------------------------------------------------
  // Pad indices
  // ------------------------------------------------------------------
  localparam int NUM_PADS      = 45;
  localparam int PAD_TS_CLK    = 0;
  localparam int PAD_UART_RTS  = 1;
  localparam int PAD_TS_SYNC   = 2;
  localparam int PAD_TS_VALID  = 3;
  localparam int PAD_TS_DATA   = 4;
  localparam int PAD_DISP_D22  = 5;
  localparam int PAD_DISP_D23  = 6;
  localparam int PAD_SPI2_BASE = 7;
  localparam int PAD_RSVD3     = 11;
  localparam int PAD_RSVD4     = 12;
  localparam int PAD_RSVD15    = 13;
  localparam int PAD_SC_VOLT   = 14;
  localparam int PAD_CE_FOURTH = 15;
  localparam int PAD_UART_CTS  = 16;
  localparam int PAD_CE_THIRD  = 17;
  localparam int PAD_NAND_D0   = 18;
  localparam int PAD_NAND_D7   = 25;
  localparam int PAD_CE_FIRST  = 26;
  localparam int PAD_CE_SECOND = 27;
  localparam int PAD_UART_TXD  = 28;
  localparam int PAD_CARD_D3   = 29;
  localparam int PAD_CARD_D0   = 32;
  localparam int PAD_RSVD14    = 33;
  localparam int PAD_RSVD7     = 40;
  localparam int PAD_DISP_D17  = 41;
  localparam int PAD_DISP_D16  = 42;
  localparam int PAD_AUDIO_FSR = 43;
  localparam int PAD_SC_FCB    = 44;

  // ------------------------------------------------------------------
  // Levels seen by a function that does not own its pad
  // ------------------------------------------------------------------
  localparam logic [NUM_PADS-1:0] MAIN_IDLE = '0;
  localparam logic [NUM_PADS-1:0] ALT_IDLE  = '0;

endpackage : pad_function_mux_pkg

// ---- hdl/pad_route_cell.sv ----
/*
  One shared pad: steers output and enable from the owning function and
  parks the input of the other function at its idle level.
  Assumes all signals are synchronous to the system clock.
*/
`timescale 1ns/1ps

module pad_route_cell #(
  parameter logic MAIN_IDLE_LVL = 1'b0,
  parameter logic ALT_IDLE_LVL  = 1'b0
) (
  // Select
  input  wire logic sel,
  // Pad side
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  // Main function
  input  wire logic main_out,
  input  wire logic main_oe,
  output logic      main_in,
  // Alternate function
  input  wire logic alt_out,
  input  wire logic alt_oe,
  output logic      alt_in
);

  // ------------------------------------------------------------------
  // Routing
  // ------------------------------------------------------------------
  // Pure gates, so the pad follows the select with no cycle of lag
  assign pad_out = sel ? alt_out : main_out;
  assign pad_oe  = sel ? alt_oe : main_oe;
  assign main_in = sel ? MAIN_IDLE_LVL : pad_in;
  assign alt_in  = sel ? pad_in : ALT_IDLE_LVL;

endmodule : pad_route_cell

// ---- verif/pad_world_model.sv ----
/*
  Model of the pads and of the on-chip peripherals around the pad mux.
  Assumes one system clock; every peripheral line moves on each rising edge.
*/
`timescale 1ns/1ps

module pad_world_model
  import pad_function_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Pad drive from the mux
  input  wire logic [NUM_PADS-1:0] pad_out,
  input  wire logic [NUM_PADS-1:0] pad_oe,
  // Pad level back to the mux
  output logic      [NUM_PADS-1:0] pad_in,
  // Peripheral drive
  output logic      [NUM_PADS-1:0] main_out,
  output logic      [NUM_PADS-1:0] main_oe,
  output logic      [NUM_PADS-1:0] alt_out,
  output logic      [NUM_PADS-1:0] alt_oe,
  output logic                     dev2_sel_out,
  output logic                     dev2_sel_oe
);
  logic [NUM_PADS-1:0] pat;

  // ------------------------------------------------------------------
  // Pattern source
  // ------------------------------------------------------------------
  // Shift register, so a stale route never matches by chance
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pat <= 45'h15A_C3F0_96E1;
    end else begin
      pat <= {pat[43:0], pat[44] ^ pat[39]};
    end
  end

  // Undriven pads float to a moving level, not to the last one
  assign pad_in       = (pad_oe & pad_out) | (~pad_oe & {pat[21:0], pat[44:22]});
  // Main and alternate drive differ on every line
  assign main_out     = pat;
  assign alt_out      = ~pat;
  assign main_oe      = {pat[10:0], pat[44:11]};
  assign alt_oe       = ~main_oe;
  assign dev2_sel_out = pat[7] ^ pat[30];
  assign dev2_sel_oe  = ~pat[3];
endmodule : pad_world_model

// ---- verif/tb.sv ----
/*
  Testbench for the pad function multiplexer: register tasks, bit walk
  over the select register and routing checks on every pad.
  Assumes the pad and peripheral model drives all pad-side inputs.
*/
`timescale 1ns/1ps

module tb;
  import pad_function_mux_pkg::*;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic                clk, resetn, wr, rd, dev2_sel_out, dev2_sel_oe, dev2_sel_in;
  logic [31:0]         addr, wdata, rdata, sel_model;
  logic [NUM_PADS-1:0] pad_in, pad_out, pad_oe, main_out, main_oe, main_in;
  logic [NUM_PADS-1:0] alt_out, alt_oe, alt_in;
  logic [SEL_W-1:0]    pad_select;
  int                  miscompares, n_compared;

  pad_function_mux #(.ADDR_W(32)) dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .main_out(main_out), .main_oe(main_oe), .main_in(main_in), .alt_out(alt_out),
    .alt_oe(alt_oe), .alt_in(alt_in), .dev2_sel_out(dev2_sel_out),
    .dev2_sel_oe(dev2_sel_oe), .dev2_sel_in(dev2_sel_in), .pad_select(pad_select));

  pad_world_model model (
    .clk(clk), .resetn(resetn), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in),
    .main_out(main_out), .main_oe(main_oe), .alt_out(alt_out), .alt_oe(alt_oe),
    .dev2_sel_out(dev2_sel_out), .dev2_sel_oe(dev2_sel_oe));

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    if (a == SEL_ADDR) sel_model = d & 32'h1FFF_FFFF;
  endtask : wr_reg

  // Read data must stand for exactly the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 cmp(rdata, exp);
    @(posedge clk);
    #1 cmp(rdata, 32'h0);
  endtask : rd_reg

  // Pads owned by the alternate function for a given selection
  function automatic logic [NUM_PADS-1:0] alt_mask(input logic [31:0] s);
    logic [NUM_PADS-1:0] m;
    m = '0;
    m[4:0]   = {s[24], s[25], s[26], s[27], s[28]};
    m[6:5]   = {2{s[23]}};
    m[10:7]  = {4{s[22]}};
    m[12:11] = {2{s[21]}};
    m[14:13] = {2{s[20]}};
    m[15]    = s[19];
    m[17:16] = {2{s[18]}};
    m[27:18] = {10{s[17]}};
    m[32:28] = {s[12], s[13], s[14], s[15], s[16]};
    m[34:33] = {s[10], s[11]};
    for (int k = 0; k < 6; k++) m[35+k] = s[9-k];
    m[44:41] = {s[0], s[1], s[2], s[3]};
    return m;
  endfunction : alt_mask

  task automatic check_routes;
    logic [NUM_PADS-1:0] m, eo, eoe, emi, eai;
    logic                d2;
    m   = alt_mask(sel_model);
    d2  = sel_model[19] & ~sel_model[27];
    eo  = (m & alt_out) | (~m & main_out);
    eoe = (m & alt_oe) | (~m & main_oe);
    emi = (~m & pad_in) | (m & MAIN_IDLE);
    eai = (m & pad_in) | (~m & ALT_IDLE);
    if (d2) begin
      eo[1]  = dev2_sel_out;
      eoe[1] = dev2_sel_oe;
      emi[1] = MAIN_IDLE[1];
    end
    cmp(pad_out, eo);
    cmp(pad_oe, eoe);
    cmp(main_in, emi);
    cmp(alt_in, eai);
    cmp(dev2_sel_in, d2 ? pad_in[1] : 1'b0);
    cmp(pad_select, sel_model[SEL_W-1:0]);
  endtask : check_routes

  // One select bit at a time; the previous one must fall back to main
  task automatic walk(input int hi, input int lo);
    for (int b = hi; b >= lo; b--) begin
      wr_reg(SEL_ADDR, 32'h1 << b);
      @(negedge clk);
      check_routes();
    end
  endtask : walk

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    sel_model = 32'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check_routes();
    rd_reg(SEL_ADDR, SEL_RESET);
    walk(28, 22);
    walk(21, 15);
    walk(14, 0);
    // All alternates at once, reserved bits must read back as zero
    wr_reg(SEL_ADDR, 32'hFFFF_FFFF);
    rd_reg(SEL_ADDR, 32'h1FFF_FFFF);
    @(negedge clk);
    check_routes();
    // Request pad claimed by both the satnav mode line and the serial device
    wr_reg(SEL_ADDR, 32'h0808_0000);
    @(negedge clk);
    check_routes();
    // Unmapped address: write ignored, read gives zero
    wr_reg(SEL_ADDR + 32'h4, 32'h0);
    rd_reg(SEL_ADDR, 32'h0808_0000);
    rd_reg(SEL_ADDR + 32'h4, 32'h0);
    // Reset in mid-run puts every pad back on its main function
    wr_reg(SEL_ADDR, 32'h1FFF_FFFF);
    @(posedge clk);
    resetn <= 1'b0;
    sel_model = 32'h0;
    @(negedge clk);
    check_routes();
    @(posedge clk);
    resetn <= 1'b1;
    rd_reg(SEL_ADDR, SEL_RESET);
    end_of_test();
  end
endmodule : tb
